/* core/lfit_pkg.sv */
// constants, types and field layout of the low-frequency interval timer
// Behaviour
// [RQ1] clock-gate enable at zero withholds the timer clock; the timer cannot operate.
// [RQ2] clock-gate enable resets to zero; software sets it before using the control register.
// [RQ3] software must not clear the clock-gate enable while the timer runs.
// [RQ4] writing one to counter run starts the binary counter on the low-frequency clock.
// [RQ5] interval select n gives a period of 2^(15-n) low-frequency cycles.
// [RQ6] each elapsed interval raises the interval request; counting continues.
// [RQ7] writing zero to counter run clears the counter to zero and halts it.
// [RQ8] interval select changes only while counter run is zero; otherwise old value stays.
// [RQ9] a starting write loads interval select; a stopping write leaves it unchanged.
// [RQ10] oscillator off, stop or deep sleep while running clears run, keeps select.
// [RQ11] counter run is zero right after reset release.
// [RQ12] timer works only while the oscillator runs and not in stop or deep sleep.
// [RQ13] counter is 15 bits; request fires when selected low bits roll over to zero.
// [RQ14] interval request leaves as a one-cycle pulse on the system clock.
package lfit_pkg;

  localparam int unsigned ADR_W = 16;
  localparam int unsigned DAT_W = 32;
  localparam int unsigned IDX_W = 12;
  localparam int unsigned CNT_W = 15;
  localparam int unsigned SEL_W = 3;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CLOCK_GATE = 12'hF76;
  localparam logic [IDX_W-1:0] IDX_CONTROL = 12'hFC8;
  localparam logic [IDX_W-1:0] IDX_COUNT = 12'hFC9;
  localparam logic [IDX_W-1:0] IDX_STATUS = 12'hFCA;
  localparam logic [IDX_W-1:0] IDX_MASK = 12'hFCB;

  // field positions
  localparam int unsigned GATE_ENABLE_POS = 5;
  localparam int unsigned STAT_INTERVAL_POS = 0;
  localparam int unsigned STAT_FORCED_STOP_POS = 1;

  // reset values
  localparam logic [7:0] CLOCK_GATE_RESET = 8'h00;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [CNT_W-1:0] COUNT_RESET = 15'h0000;
  localparam logic [SEL_W-1:0] SELECT_RESET = 3'h0;

  typedef enum logic [1:0] {
    LFIT_IDLE = 2'b01,
    LFIT_RUN = 2'b10
  } lfit_state_t;

  typedef struct packed {
    logic [3:0] zero;
    logic [SEL_W-1:0] interval_select;
    logic counter_run;
  } lfit_ctrl_t;

  typedef struct packed {
    logic [5:0] zero;
    logic forced_stop;
    logic interval;
  } lfit_event_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [IDX_W-1:0] idx;
    logic [7:0] data;
  } lfit_access_t;

endpackage

/* core/lfit_sync.sv */
// three-stage synchroniser with agreement filter and rising-edge pulse
`timescale 1ns/1ps
module lfit_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic pin_i,
  output logic rise_o
);

  logic stage1;
  logic stage2;
  logic stage3;
  logic level;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else if (ce_i) begin
      stage1 <= pin_i;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // a change counts once the last two stages agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level <= 1'b0;
      rise_o <= 1'b0;
    end else if (ce_i) begin
      rise_o <= (stage2 == stage3) && stage3 && !level;
      if (stage2 == stage3) begin
        level <= stage3;
      end
    end
  end

endmodule // lfit_sync

/* core/lfit_counter.sv */
// binary counter with interval roll-over detection
`timescale 1ns/1ps
module lfit_counter #(
  parameter int unsigned WIDTH = lfit_pkg::CNT_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic clear_i,
  input wire logic tick_i,
  input wire logic [lfit_pkg::SEL_W-1:0] sel_i,
  output logic [WIDTH-1:0] count_o,
  output logic hit_o
);

  logic [WIDTH-1:0] next_count;
  logic [WIDTH-1:0] low_zero;

  assign next_count = count_o + {{(WIDTH-1){1'b0}}, 1'b1};

  // bit i counts toward the interval when i < WIDTH - sel
  for (genvar i = 0; i < WIDTH; i++) begin : g_zero
    assign low_zero[i] = (i >= (int'(WIDTH) - int'(sel_i))) || !next_count[i]; // [RQ5] [RQ13]
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_o <= lfit_pkg::COUNT_RESET;
    end else if (ce_i) begin
      if (clear_i) begin
        count_o <= lfit_pkg::COUNT_RESET; // [RQ7]
      end else if (tick_i) begin
        count_o <= next_count; // [RQ4] [RQ6]
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hit_o <= 1'b0;
    end else if (ce_i) begin
      hit_o <= tick_i && !clear_i && (&low_zero); // [RQ6] [RQ13]
    end
  end

endmodule // lfit_counter

/* core/lfit_top.sv */
// low-frequency interval timer with wishbone register slave
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ps
module lfit_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [lfit_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [lfit_pkg::DAT_W-1:0] wb_dat_i,
  output logic [lfit_pkg::DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic low_freq_clock_i,
  input wire logic low_freq_osc_enable_i,
  input wire logic stop_mode_i,
  input wire logic deep_sleep_mode_i,
  output logic interval_irq_o,
  output logic irq_o,
  output logic counter_run_o
);

  localparam int unsigned N_HALT = 3;
  localparam int unsigned HALT_OSC = 0;
  localparam int unsigned HALT_STOP = 1;
  localparam int unsigned HALT_SLEEP = 2;

  // register state
  logic [7:0] peripheral_clock_gate_2;
  logic [lfit_pkg::SEL_W-1:0] interval_select;
  logic [7:0] status;
  logic [7:0] mask;
  lfit_pkg::lfit_ctrl_t control_view;
  lfit_pkg::lfit_state_t state;
  lfit_pkg::lfit_state_t next_state;

  // bus decode
  lfit_pkg::lfit_access_t access;
  logic bus_req;
  logic sel_clock_gate;
  logic sel_control;
  logic sel_status;
  logic sel_mask;
  logic wr_clock_gate;
  logic wr_status;
  logic wr_mask;
  lfit_pkg::lfit_ctrl_t wr_ctrl;
  lfit_pkg::lfit_ctrl_t rd_ctrl;
  logic [7:0] read_byte;
  logic [7:0] status_clear;

  // timer datapath
  logic gate_on;
  logic timer_ce;
  logic running;
  logic lf_rise;
  logic tick;
  logic hit;
  logic [lfit_pkg::CNT_W-1:0] count;
  lfit_pkg::lfit_event_t set_event;

  // halt sources
  logic [N_HALT-1:0] halt_pin;
  logic [N_HALT-1:0] halt_on;
  logic [N_HALT-1:0] halt_off;
  logic [N_HALT-1:0] halt_level;
  logic halt_any;
  logic forced_stop;

  // control requests
  logic ctrl_write;
  logic start_req;
  logic stop_req;

  // bus access of the current cycle; a write lands at the acknowledged edge
  assign bus_req = wb_cyc_i && wb_stb_i;
  assign access.rd = bus_req && !wb_we_i;
  assign access.wr = bus_req && wb_we_i && wb_ack_o && wb_sel_i[0];
  assign access.idx = wb_adr_i[lfit_pkg::IDX_W+1:2];
  assign access.data = wb_dat_i[7:0];

  assign sel_clock_gate = (access.idx == lfit_pkg::IDX_CLOCK_GATE);
  assign sel_control = (access.idx == lfit_pkg::IDX_CONTROL);
  assign sel_status = (access.idx == lfit_pkg::IDX_STATUS);
  assign sel_mask = (access.idx == lfit_pkg::IDX_MASK);
  assign wr_clock_gate = access.wr && sel_clock_gate;
  assign wr_status = access.wr && sel_status;
  assign wr_mask = access.wr && sel_mask;

  // acknowledge one cycle after the request, dropped in the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else if (ce_i) begin
      wb_ack_o <= bus_req && !wb_ack_o;
    end
  end

  // read view of the control register
  assign rd_ctrl.zero = 4'h0;
  assign rd_ctrl.interval_select = interval_select;
  assign rd_ctrl.counter_run = running;

  // registered image of the control register for reads
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      control_view <= lfit_pkg::lfit_ctrl_t'(lfit_pkg::CONTROL_RESET);
    end else if (ce_i) begin
      control_view <= rd_ctrl;
    end
  end

  always_comb begin
    read_byte = 8'h00;
    case (access.idx)
      lfit_pkg::IDX_CLOCK_GATE: begin
        read_byte = peripheral_clock_gate_2;
      end
      lfit_pkg::IDX_CONTROL: begin
        read_byte = control_view;
      end
      lfit_pkg::IDX_COUNT: begin
        read_byte = count[7:0];
      end
      lfit_pkg::IDX_STATUS: begin
        read_byte = status;
      end
      lfit_pkg::IDX_MASK: begin
        read_byte = mask;
      end
      default: begin
        read_byte = 8'h00;
      end
    endcase
  end

  // read data stands while acknowledge is high; upper lanes read as zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (ce_i) begin
      if (access.rd && !wb_ack_o) begin
        wb_dat_o <= {{(lfit_pkg::DAT_W-8){1'b0}}, read_byte};
      end
    end
  end

  // clock gate register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      peripheral_clock_gate_2 <= lfit_pkg::CLOCK_GATE_RESET; // [RQ2]
    end else if (ce_i && wr_clock_gate) begin
      peripheral_clock_gate_2 <= access.data;
    end
  end

  // the timer domain freezes with the gate off; clearing it while running
  // leaves the count stranded until the gate comes back
  assign gate_on = peripheral_clock_gate_2[lfit_pkg::GATE_ENABLE_POS];
  assign timer_ce = ce_i && gate_on; // [RQ1]

  // stop conditions, each active high
  always_comb begin
    halt_pin = '0;
    halt_pin[HALT_OSC] = !low_freq_osc_enable_i;
    halt_pin[HALT_STOP] = stop_mode_i;
    halt_pin[HALT_SLEEP] = deep_sleep_mode_i;
  end

  for (genvar k = 0; k < N_HALT; k++) begin : g_halt
    logic level;
    logic pin_n;

    assign pin_n = !halt_pin[k];

    lfit_sync u_on_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .pin_i(halt_pin[k]),
      .rise_o(halt_on[k])
    );

    lfit_sync u_off_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .pin_i(pin_n),
      .rise_o(halt_off[k])
    );

    // both edges are filtered so a glitch on the pin cannot flip the level
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        level <= 1'b0;
      end else if (ce_i) begin
        if (halt_on[k]) begin
          level <= 1'b1;
        end else if (halt_off[k]) begin
          level <= 1'b0;
        end
      end
    end

    assign halt_level[k] = level;
  end

  // an edge blocks a start even before the level flop follows it
  assign halt_any = (|halt_on) || (|halt_level); // [RQ10] [RQ12]

  // low-frequency clock edges, sampled only while the gate is on
  lfit_sync u_lf_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(timer_ce),
    .pin_i(low_freq_clock_i),
    .rise_o(lf_rise)
  );

  // control writes need the clock gate on; a start refused in a halt stays idle
  assign ctrl_write = access.wr && sel_control && gate_on; // [RQ2]
  assign wr_ctrl = lfit_pkg::lfit_ctrl_t'(access.data);
  assign start_req = ctrl_write && wr_ctrl.counter_run && !halt_any; // [RQ4] [RQ12]
  assign stop_req = ctrl_write && !wr_ctrl.counter_run; // [RQ7]
  assign running = (state == lfit_pkg::LFIT_RUN);
  assign forced_stop = running && halt_any; // [RQ10]

  // run state: idle until software starts it, back to idle on stop or halt
  always_comb begin
    next_state = state;
    case (state)
      lfit_pkg::LFIT_IDLE: begin
        if (start_req) begin
          next_state = lfit_pkg::LFIT_RUN; // [RQ4]
        end
      end
      lfit_pkg::LFIT_RUN: begin
        if (forced_stop || stop_req) begin
          next_state = lfit_pkg::LFIT_IDLE; // [RQ7] [RQ10]
        end
      end
      default: begin
        next_state = lfit_pkg::LFIT_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= lfit_pkg::LFIT_IDLE; // [RQ11]
      counter_run_o <= 1'b0; // [RQ11]
    end else if (ce_i) begin
      state <= next_state;
      counter_run_o <= (next_state == lfit_pkg::LFIT_RUN);
    end
  end

  // interval select loads only from idle, so a stopping write keeps it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      interval_select <= lfit_pkg::SELECT_RESET;
    end else if (ce_i && ctrl_write && !running) begin
      interval_select <= wr_ctrl.interval_select; // [RQ8] [RQ9] [RQ10]
    end
  end

  // held at zero while idle, so every start begins a full interval
  assign tick = lf_rise && running; // [RQ4]

  lfit_counter #(
    .WIDTH(lfit_pkg::CNT_W)
  ) u_counter (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(timer_ce),
    .clear_i(!running),
    .tick_i(tick),
    .sel_i(interval_select),
    .count_o(count),
    .hit_o(hit)
  );

  // single system-clock pulse; gated so a frozen hit is not repeated
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      interval_irq_o <= 1'b0;
    end else if (ce_i) begin
      interval_irq_o <= hit && timer_ce; // [RQ6] [RQ14]
    end
  end

  // sticky events
  assign set_event.zero = 6'h00;
  assign set_event.interval = hit && timer_ce; // [RQ6]
  assign set_event.forced_stop = forced_stop; // [RQ10]

  always_comb begin
    status_clear = 8'h00;
    if (wr_status) begin
      status_clear = access.data;
    end
  end

  // write one to clear; set beats clear so an event is never lost
  for (genvar b = 0; b < 8; b++) begin : g_status
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        status[b] <= lfit_pkg::STATUS_RESET[b];
      end else if (ce_i) begin
        if (set_event[b]) begin
          status[b] <= 1'b1;
        end else if (status_clear[b]) begin
          status[b] <= 1'b0;
        end
      end
    end
  end

  // interrupt mask
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask <= lfit_pkg::MASK_RESET;
    end else if (ce_i && wr_mask) begin
      mask <= access.data;
    end
  end

  // level interrupt while an unmasked event is pending
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= |(status & mask);
    end
  end

endmodule // lfit_top

/* verification/lfit_props.sv */
// port assertions of the interval timer
`timescale 1ns/1ps
module lfit_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_we_i,
  input wire logic low_freq_clock_i,
  input wire logic low_freq_osc_enable_i,
  input wire logic stop_mode_i,
  input wire logic deep_sleep_mode_i,
  input wire logic interval_irq_o,
  input wire logic irq_o,
  input wire logic counter_run_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_run_after_reset: assert property ($fell(rst_i) |-> !counter_run_o) else $error("run");
  a_osc_off_stop: assert property (!low_freq_osc_enable_i |-> ##[1:6] !counter_run_o) else $error("osc");
  a_stop_mode_stop: assert property (stop_mode_i |-> ##[1:6] !counter_run_o) else $error("stop");
  a_sleep_stop: assert property (deep_sleep_mode_i |-> ##[1:6] !counter_run_o) else $error("sleep");
  a_irq_one_cycle: assert property (interval_irq_o |=> !interval_irq_o) else $error("pulse");
  a_idle_no_irq: assert property (!counter_run_o [*8] |-> !interval_irq_o) else $error("idle");
  a_quiet_no_irq: assert property ($stable(low_freq_clock_i) [*8] |-> !interval_irq_o) else $error("lf");
  a_run_holds: assert property (counter_run_o && low_freq_osc_enable_i && !stop_mode_i && !deep_sleep_mode_i
    && !wb_we_i |=> counter_run_o) else $error("hold");
  cover property (interval_irq_o);
  cover property ($fell(counter_run_o));
  cover property (irq_o);
endmodule // lfit_props
bind lfit_top lfit_props u_props (.*);

/* verification/testbench.sv */
// self-checking bench of the interval timer
`timescale 1ns/1ps
module testbench;
  logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, lf = 0, osc = 1, stp = 0, slp = 0, ack, irq, ii, run;
  logic [15:0] adr = 0;
  logic [31:0] wd = 0, rd;
  logic [7:0] rv;
  int n_fail = 0, compares = 0, cyc_n = 0, pulses = 0;
  lfit_top dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack), .low_freq_clock_i(lf),
    .low_freq_osc_enable_i(osc), .stop_mode_i(stp), .deep_sleep_mode_i(slp), .interval_irq_o(ii),
    .irq_o(irq), .counter_run_o(run));
  initial forever #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc_n++;
    if (ii === 1'b1) pulses++;
    if (cyc_n == 20000) begin
      n_fail++;
      finish_test();
    end
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] idx, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1;
    we <= w;
    adr <= {2'h0, idx, 2'h0};
    wd <= {24'h0, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    rv = rd[7:0];
    cyc <= 0;
    we <= 0;
  endtask
  task automatic rc(input logic [11:0] idx, input logic [7:0] exp);
    bus(0, idx, 8'h00);
    check(rv, exp);
  endtask
  task automatic lf_run(input int n);
    repeat (n) begin
      repeat (4) @(posedge clk_i);
      lf <= ~lf;
    end
  endtask
  task automatic t_reset;
    rc(lfit_pkg::IDX_CLOCK_GATE, 8'h00);
    rc(lfit_pkg::IDX_CONTROL, 8'h00);
  endtask
  task automatic t_interval;
    bus(1, lfit_pkg::IDX_CLOCK_GATE, 8'h20);
    bus(1, lfit_pkg::IDX_MASK, 8'h01);
    bus(1, lfit_pkg::IDX_CONTROL, 8'h0F);
    pulses = 0;
    lf_run(600);
    check(8'(pulses), 8'h01);
    check({7'h0, irq}, 8'h01);
    bus(1, lfit_pkg::IDX_CONTROL, 8'h05);
    rc(lfit_pkg::IDX_CONTROL, 8'h0F);
    bus(1, lfit_pkg::IDX_STATUS, 8'h01);
    bus(1, lfit_pkg::IDX_CONTROL, 8'h00);
    check({7'h0, irq}, 8'h00);
    rc(lfit_pkg::IDX_CONTROL, 8'h0E);
    pulses = 0;
    lf_run(600);
    check(8'(pulses), 8'h00);
  endtask
  task automatic t_forced;
    for (int k = 0; k < 3; k++) begin
      bus(1, lfit_pkg::IDX_CONTROL, 8'h0F);
      @(posedge clk_i);
      check({7'h0, run}, 8'h01);
      osc <= (k != 0);
      stp <= (k == 1);
      slp <= (k == 2);
      repeat (8) @(posedge clk_i);
      check({7'h0, run}, 8'h00);
      osc <= 1;
      stp <= 0;
      slp <= 0;
      repeat (8) @(posedge clk_i);
      rc(lfit_pkg::IDX_CONTROL, 8'h0E);
    end
  endtask
  task automatic finish_test;
    $display("mismatches %0d compares %0d", n_fail, compares);
    if (n_fail == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 0;
    t_reset();
    t_interval();
    t_forced();
    finish_test();
  end
endmodule // testbench
